// [hdl/usbcr_ctrl_regs.v]
// APB register block for USB line, power, address and endpoint control
`include "usbcr_regs.vh"
`default_nettype none

// Register map: one byte per 32-bit word, byte address is four times the index.
//   Index 195h: line and power control (live SE0, packet hold, attach, resume, suspend)
//   Index 196h: device address, seven bits, bit 7 always reads zero
//   Index 197h: firmware enumeration status byte, all eight bits stored
//   Index 198h to 19Ah: endpoint control nibbles for endpoints zero to two
// Bus timing: every access is one setup cycle and one access cycle. Ready is never
// held off, so firmware sees no wait states. Unmapped or misaligned addresses answer
// with an error and zero data, and writes to them are dropped.
// Token timing: the engine shows a token for one cycle and gets exactly one of
// accept, stall or ignore in the next cycle. The answer is decided from the register
// values that stand in the token cycle.
// Line timing: the data lines are registered once here, so every consumer sees the
// same sample. Bus reset and idle times count from that sample.
// A bus reset clears the address and all endpoint nibbles but leaves attach, resume,
// suspend and the status byte alone, so a host reset cannot detach the device.
// Packet hold is set only by the engine. Firmware can only clear it, and only while
// not suspended. Writing a one to the hold bit has no effect.
// Endpoint answers: halt with any direction enabled answers STALL before the enable
// decode is looked at. A halted endpoint with both directions off is simply disabled.
// SETUP needs both directions on and the control-disable bit off.
// Halt events from the engine override a firmware write in the same cycle, and a set
// outranks a clear, so a protocol stall is never lost.
// Pin controls are registered copies of the control bits, one cycle behind a write,
// so the pins never glitch while the bus decode settles.
// Clock gating: the engine clock enable drops while suspended. The register side keeps
// running on the system clock, so firmware can still leave suspend.
// Limitation: resume drive is gated by attach only. Firmware must leave suspend before
// it asks for resume, or the transceiver stays off.

module usbcr_ctrl_regs #(
  parameter IDLE_CYC = `USBCR_IDLE_CYC,
  parameter NUM_EP = 3
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // USB data lines, synchronous to clk_sys
  input wire lineDp,
  input wire lineDm,
  // Engine events
  input wire setupHoldReq,
  input wire [NUM_EP-1:0] haltSet,
  input wire [NUM_EP-1:0] haltClr,
  // Token lookup from the engine
  input wire tokValid,
  input wire [6:0] tokAddr,
  input wire [1:0] tokEp,
  input wire [1:0] tokKind,
  output reg tokAccept,
  output reg tokStall,
  output reg tokIgnore,
  // Line and power control
  output reg busSupplyEn,
  output reg xcvrOutEn,
  output reg resumeDrive,
  output reg usbClkEn,
  output reg packetHold,
  // Bus detections
  output reg busResetPulse,
  output reg busIdleFlag,
  output reg [1:0] enumState
);

// Register index from a byte address, without any validity check
function [11:0] regIdx;
  input [13:0] a;
  begin
    regIdx = a[13:2];
  end
endfunction

// Allowed token kinds for one endpoint control nibble
function epAllows;
  input [3:0] ep;
  input [1:0] kind;
  begin
    case (kind)
      `USBCR_PID_IN: epAllows = ep[`USBCR_EP_INEN];
      `USBCR_PID_OUT: epAllows = ep[`USBCR_EP_OUTEN];
      `USBCR_PID_SETUP: epAllows = ep[`USBCR_EP_INEN] & ep[`USBCR_EP_OUTEN] & ~ep[`USBCR_EP_CTLDIS];
      default: epAllows = 1'b0;
    endcase
  end
endfunction

// Line sampling
reg dpQ;
reg dmQ;
wire se0 = ~dpQ & ~dmQ;
wire idleState = ~dpQ & dmQ;
wire busReset;
wire busIdle;

// Control and configuration state
reg attach;
reg resume;
reg suspend;
reg [6:0] devAddr;
reg [7:0] fwStatus;
reg [3:0] epCtl [0:NUM_EP-1];
integer i;

// APB phase decode
wire setup = psel & ~penable;
wire wrEn = psel & penable & pready & pwrite;
wire [11:0] wIdx = regIdx(paddr);
wire aligned = (paddr[1:0] == 2'h0);
wire mapped = aligned & (wIdx >= `USBCR_IDX_CTRL) & (wIdx <= `USBCR_IDX_EP2);
wire wrCtrl = wrEn & aligned & (wIdx == `USBCR_IDX_CTRL);
wire wrAddr = wrEn & aligned & (wIdx == `USBCR_IDX_ADDR);
wire wrFwst = wrEn & aligned & (wIdx == `USBCR_IDX_FWST);
wire [11:0] epOff = wIdx - `USBCR_IDX_EP0;
// Endpoint writes share one strobe; the offset picks the nibble
wire epWrAny = wrEn & aligned & (wIdx >= `USBCR_IDX_EP0) & (wIdx <= `USBCR_IDX_EP2);
// Hold may change only out of suspend, for the engine and firmware alike
wire holdSet = setupHoldReq & ~suspend;
wire holdClr = wrCtrl & ~suspend & ~pwdata[`USBCR_CTRL_HOLD];

// Bus reset and idle timing
usbcr_line_timer #(
  .RST_CYC(`USBCR_BUSRST_CYC),
  .IDLE_CYC(IDLE_CYC)
) u_timer (
  .clk_sys(clk_sys),
  .rst(rst),
  .se0(se0),
  .idleState(idleState),
  .busReset(busReset),
  .busIdle(busIdle)
);

// Line inputs taken once so reads and timers see one value
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    dpQ <= 1'b0;
    dmQ <= 1'b1;
  end
  else
  begin
    dpQ <= lineDp;
    dmQ <= lineDm;
  end
end

// Attach, resume and suspend are plain software bits
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    attach <= 1'b0;
    resume <= 1'b0;
    suspend <= 1'b0;
  end
  else if (wrCtrl)
  begin
    attach <= pwdata[`USBCR_CTRL_ATTACH];
    resume <= pwdata[`USBCR_CTRL_RESUME];
    suspend <= pwdata[`USBCR_CTRL_SUSPEND];
  end
end

// Packet hold: engine sets, software may only clear, and only out of suspend.
// A set in the clearing cycle wins so a fresh SETUP hold is never lost.
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
    packetHold <= 1'b0;
  else if (holdSet)
    packetHold <= 1'b1;
  else if (holdClr)
    packetHold <= 1'b0;
end

// Device address: cleared by chip reset and by a decoded bus reset
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
    devAddr <= `USBCR_RST_ADDR;
  else if (busReset)
    devAddr <= `USBCR_RST_ADDR;
  else if (wrAddr)
    devAddr <= pwdata[6:0];
end

// Firmware status byte; the library owns it, hardware only stores it
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
    fwStatus <= `USBCR_RST_FWST;
  else if (wrFwst)
    fwStatus <= pwdata[7:0];
end

// Endpoint control: bus reset reinitialises, engine halt events override writes
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    for (i = 0; i < NUM_EP; i = i + 1)
      epCtl[i] <= `USBCR_RST_EP;
  end
  else if (busReset)
  begin
    for (i = 0; i < NUM_EP; i = i + 1)
      epCtl[i] <= `USBCR_RST_EP;
  end
  else
  begin
    for (i = 0; i < NUM_EP; i = i + 1)
    begin
      if (epWrAny && epOff == i)
        epCtl[i] <= pwdata[3:0];
      if (haltSet[i])
        epCtl[i][`USBCR_EP_HALT] <= 1'b1;
      else if (haltClr[i])
        epCtl[i][`USBCR_EP_HALT] <= 1'b0;
    end
  end
end

// Read data and ready are prepared in the setup cycle, so access is one cycle
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    prdata <= 32'h00000000;
    pready <= 1'b0;
    pslverr <= 1'b0;
  end
  else
  begin
    pready <= setup;
    pslverr <= setup & ~mapped;
    prdata <= 32'h00000000;
    if (setup && mapped)
    begin
      case (wIdx)
        `USBCR_IDX_CTRL:
          prdata <= {26'h0000000, se0, packetHold, attach, resume, suspend, 1'b0};
        `USBCR_IDX_ADDR: prdata <= {25'h0000000, devAddr};
        `USBCR_IDX_FWST: prdata <= {24'h000000, fwStatus};
        `USBCR_IDX_EP0: prdata <= {28'h0000000, epCtl[0]};
        `USBCR_IDX_EP1: prdata <= {28'h0000000, epCtl[1]};
        `USBCR_IDX_EP2: prdata <= {28'h0000000, epCtl[2]};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
end

// Token lookup: address match, endpoint range, then halt before enables
reg [3:0] tokCtl;
reg tokMine;
reg tokHalted;
always @*
begin
  tokCtl = (tokEp < NUM_EP) ? epCtl[tokEp] : 4'h0;
  tokMine = tokValid & (tokAddr == devAddr) & (tokEp < NUM_EP);
  tokHalted = tokCtl[`USBCR_EP_HALT] & (tokCtl[`USBCR_EP_INEN] | tokCtl[`USBCR_EP_OUTEN]);
end

// Held or suspended engine answers nothing; stall outranks the enable decode
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    tokAccept <= 1'b0;
    tokStall <= 1'b0;
    tokIgnore <= 1'b0;
  end
  else
  begin
    tokAccept <= 1'b0;
    tokStall <= 1'b0;
    tokIgnore <= 1'b0;
    if (tokValid)
    begin
      if (!tokMine || suspend || packetHold)
        tokIgnore <= 1'b1;
      else if (tokHalted)
        tokStall <= 1'b1;
      else if (epAllows(tokCtl, tokKind))
        tokAccept <= 1'b1;
      else
        tokIgnore <= 1'b1;
    end
  end
end

// Pin and clock controls; suspend keeps the supply but drops transceiver and clock
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    busSupplyEn <= 1'b0;
    xcvrOutEn <= 1'b0;
    resumeDrive <= 1'b0;
    usbClkEn <= 1'b0;
  end
  else
  begin
    busSupplyEn <= attach;
    xcvrOutEn <= attach & ~suspend;
    resumeDrive <= attach & resume;
    usbClkEn <= ~suspend;
  end
end

// Detections and enumeration state pass out registered
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    busResetPulse <= 1'b0;
    busIdleFlag <= 1'b0;
    enumState <= `USBCR_ENUM_POWERED;
  end
  else
  begin
    busResetPulse <= busReset;
    busIdleFlag <= busIdle;
    enumState <= fwStatus[1:0];
  end
end

endmodule // usbcr_ctrl_regs
`default_nettype wire

// [hdl/usbcr_regs.vh]
// Register map, field positions, reset values and timing counts of the USB control registers
// Contract
// - Live line-state bit reads 1 while both data lines are low.
// - Engine sets packet hold and stops tokens on certain SETUP conditions.
// - Firmware clears packet hold; changes accepted only while suspend is 0.
// - Attach drives the bus supply output; cleared leaves outputs high impedance.
// - Resume bit drives resume signalling; firmware holds it 10 ms for wake-up.
// - Suspend stops operation and clocks, disables transceiver, keeps supply driven.
// - Device address resets to zero on chip reset and on bus reset.
// - Only tokens matching the 7-bit address are decoded; bit 7 reads 0.
// - Enumeration status: 00 powered, 01 default, 10 addressed, 11 configured.
// - Six endpoint directions: endpoints zero to two, each OUT and IN.
// - Enable bits decode to disabled, IN only, OUT only, IN+OUT, or +SETUP.
// - Halt with a direction enabled answers any access with STALL.
// - Engine can set or clear each endpoint halt bit.
// - Endpoint control registers reinitialise on a bus reset.
// - Bus reset flagged after 2.5 us, again only after removal and reassertion.
// - Idle flag after 3 ms constant idle; activity restarts the timer.
`ifndef USBCR_REGS_VH
`define USBCR_REGS_VH

// Register indices; the byte address is four times the index
`define USBCR_IDX_CTRL 12'h195
`define USBCR_IDX_ADDR 12'h196
`define USBCR_IDX_FWST 12'h197
`define USBCR_IDX_EP0 12'h198
`define USBCR_IDX_EP1 12'h199
`define USBCR_IDX_EP2 12'h19a

// Control register fields
`define USBCR_CTRL_SE0 5
`define USBCR_CTRL_HOLD 4
`define USBCR_CTRL_ATTACH 3
`define USBCR_CTRL_RESUME 2
`define USBCR_CTRL_SUSPEND 1

// Endpoint control fields
`define USBCR_EP_CTLDIS 3
`define USBCR_EP_OUTEN 2
`define USBCR_EP_INEN 1
`define USBCR_EP_HALT 0

// Enumeration states
`define USBCR_ENUM_POWERED 2'h0
`define USBCR_ENUM_DEFAULT 2'h1
`define USBCR_ENUM_ADDRESSED 2'h2
`define USBCR_ENUM_CONFIGURED 2'h3

// Token kinds presented by the engine
`define USBCR_PID_OUT 2'h0
`define USBCR_PID_IN 2'h1
`define USBCR_PID_SETUP 2'h2

// Reset values
`define USBCR_RST_ADDR 7'h00
`define USBCR_RST_EP 4'h0
`define USBCR_RST_FWST 8'h00

// Timing: clock period, bus reset and idle times
`define USBCR_CLK_NS 100
`define USBCR_BUSRST_NS 2500
`define USBCR_BUSRST_CYC ((`USBCR_BUSRST_NS + `USBCR_CLK_NS - 1) / `USBCR_CLK_NS)
`define USBCR_IDLE_US 3000
`define USBCR_IDLE_CYC ((`USBCR_IDLE_US * 1000) / `USBCR_CLK_NS)

`endif

// [hdl/usbcr_line_timer.v]
// Bus reset and idle detection on the sampled data lines
`include "usbcr_regs.vh"
`default_nettype none

module usbcr_line_timer #(
  parameter RST_CYC = `USBCR_BUSRST_CYC,
  parameter IDLE_CYC = `USBCR_IDLE_CYC
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Sampled line state
  input wire se0,
  input wire idleState,
  // Detections
  output reg busReset,
  output reg busIdle
);

reg [4:0] rstCnt;
reg rstSeen;
reg [15:0] idleCnt;

// Reset count saturates; the flag pulses once per SE0 episode
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    rstCnt <= 5'h00;
    rstSeen <= 1'b0;
    busReset <= 1'b0;
  end
  else
  begin
    busReset <= 1'b0;
    if (!se0)
    begin
      rstCnt <= 5'h00;
      rstSeen <= 1'b0;
    end
    else if (!rstSeen)
    begin
      if (rstCnt == RST_CYC[4:0] - 5'h01)
      begin
        busReset <= 1'b1;
        rstSeen <= 1'b1;
      end
      else
        rstCnt <= rstCnt + 5'h01;
    end
  end
end

// Any non-idle line state restarts the idle timer
always @(posedge clk_sys or posedge rst)
begin
  if (rst)
  begin
    idleCnt <= 16'h0000;
    busIdle <= 1'b0;
  end
  else if (!idleState)
  begin
    idleCnt <= 16'h0000;
    busIdle <= 1'b0;
  end
  else if (idleCnt == IDLE_CYC[15:0] - 16'h0001)
    busIdle <= 1'b1;
  else
    idleCnt <= idleCnt + 16'h0001;
end

endmodule // usbcr_line_timer
`default_nettype wire

// [test/usbcr_host_model.sv]
// Host-side line driver: idle, bus reset and activity
`default_nettype none
module usbcr_host_model (
  // Clock
  input wire logic clk_sys,
  // Line state: 0 idle, 1 bus reset, 2 activity
  input wire logic [1:0] mode,
  // Data lines
  output logic lineDp,
  output logic lineDm
);
  timeunit 1ns;
  timeprecision 1ns;
  // Low-speed idle holds D- high; lines change only after an edge
  initial
  begin
    lineDp = 1'b0;
    lineDm = 1'b1;
  end
  always @(posedge clk_sys)
  begin
    lineDp <= (mode == 2'h2);
    lineDm <= (mode == 2'h0);
  end
endmodule // usbcr_host_model
`default_nettype wire

// [test/usbcr_ctrl_regs_chk.sv]
// Assertion checker for the USB control register block
`default_nettype none
module usbcr_ctrl_regs_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus and lines
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lineDp,
  input wire logic lineDm,
  // Engine side and outputs
  input wire logic setupHoldReq,
  input wire logic tokValid,
  input wire logic tokAccept,
  input wire logic tokStall,
  input wire logic tokIgnore,
  input wire logic busSupplyEn,
  input wire logic xcvrOutEn,
  input wire logic resumeDrive,
  input wire logic usbClkEn,
  input wire logic packetHold,
  input wire logic busResetPulse,
  input wire logic busIdleFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] seCnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Consecutive SE0 samples; saturates so a long reset cannot wrap
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) seCnt <= 6'h00;
    else if (lineDp | lineDm) seCnt <= 6'h00;
    else if (seCnt != 6'h3f) seCnt <= seCnt + 6'h01;
  sequence setupPh;
    psel && !penable;
  endsequence
  sequence tokIn;
    tokValid;
  endsequence
  AST_APB: assert property (setupPh |=> pready)
    else $error("no ready after setup");
  AST_ERR: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  AST_TOK: assert property (tokIn |=> $onehot({tokAccept, tokStall, tokIgnore}))
    else $error("token answer not single");
  AST_SUSP: assert property (tokIn ##1 !usbClkEn |-> tokIgnore)
    else $error("token served while suspended");
  AST_HOLDT: assert property (tokIn ##0 packetHold |=> tokIgnore)
    else $error("token served while held");
  AST_HOLDS: assert property ($rose(packetHold) |-> $past(setupHoldReq))
    else $error("hold set without engine request");
  AST_XCVR: assert property (xcvrOutEn |-> busSupplyEn && usbClkEn)
    else $error("transceiver on while suspended");
  AST_RES: assert property (resumeDrive |-> busSupplyEn)
    else $error("resume without attach");
  AST_BRST: assert property (busResetPulse |-> seCnt >= 6'd25 && seCnt <= 6'd27)
    else $error("bus reset pulse at wrong time");
  AST_IDLE: assert property ((lineDp || !lineDm) [*4] |-> !busIdleFlag)
    else $error("idle flag during activity");
endmodule // usbcr_ctrl_regs_chk
`default_nettype wire

// [test/usbcr_ctrl_regs_bench.sv]
// Self-checking bench for the USB control register block
`include "usbcr_regs.vh"
`default_nettype none
module usbcr_ctrl_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE = 50;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, lineDp, lineDm, setupHoldReq, tokValid;
  logic tokAccept, tokStall, tokIgnore, busSupplyEn, xcvrOutEn, resumeDrive, usbClkEn, packetHold;
  logic busResetPulse, busIdleFlag, erv;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0] enumState, tokEp, tokKind, mode;
  logic [2:0] haltSet, haltClr;
  logic [6:0] tokAddr;
  int error_cnt, total_checks, cyc, mAddr, mOff, pulses, i, k;
  int mEp [3];
  usbcr_ctrl_regs #(.IDLE_CYC(IDLE)) dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .lineDp, .lineDm, .setupHoldReq, .haltSet, .haltClr, .tokValid, .tokAddr,
    .tokEp, .tokKind, .tokAccept, .tokStall, .tokIgnore, .busSupplyEn, .xcvrOutEn, .resumeDrive,
    .usbClkEn, .packetHold, .busResetPulse, .busIdleFlag, .enumState);
  usbcr_host_model host_u (.clk_sys, .mode, .lineDp, .lineDm);
  // 10 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; the wait is bounded only by the global timeout
  task automatic apb(input logic isWr, input logic [11:0] idx, input logic [7:0] wd, output logic [31:0] rdat,
    output logic err);
    psel <= 1'b1;
    pwrite <= isWr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'($urandom), wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-drives psel in this time step
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input logic [11:0] idx, input int exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(nm, r, exp);
  endtask
  // Model answer: 0 ignore, 1 accept, 2 stall
  function automatic int tokExp(int ep, int kind, int adr);
    int c;
    c = (ep < 3) ? mEp[ep] : 0;
    if (mOff != 0 || adr != mAddr || ep > 2) return 0;
    if ((c & 1) && (c & 6)) return 2;
    if (kind == 0 && (c & 4) || kind == 1 && (c & 2) || kind == 2 && (c & 14) == 6) return 1;
    return 0;
  endfunction
  task automatic tok(input int ep, input int kind, input int adr);
    tokValid <= 1'b1;
    tokEp <= ep[1:0];
    tokKind <= kind[1:0];
    tokAddr <= adr[6:0];
    @(posedge clk_sys);
    tokValid <= 1'b0;
    #1;
    chk("tok", {tokStall, tokAccept, tokIgnore}, 1 << tokExp(ep, kind, adr));
    @(posedge clk_sys);
  endtask
  task automatic pwr(input logic [3:0] exp);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pwr", {busSupplyEn, xcvrOutEn, resumeDrive, usbClkEn}, exp);
    @(posedge clk_sys);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard and bus reset pulse count
  always @(posedge clk_sys)
  begin
    cyc++;
    if (busResetPulse === 1'b1) pulses++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    {rst, psel, penable, pwrite, setupHoldReq, tokValid} = 6'h20;
    {paddr, pwdata, tokEp, tokKind, tokAddr, haltSet, haltClr, mode} = '0;
    void'($urandom(32'h5736));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`USBCR_IDX_ADDR, 0, "addr");
    rd(`USBCR_IDX_CTRL, 0, "ctrl");
    mAddr = $urandom_range(127, 1);
    wr(`USBCR_IDX_ADDR, 8'(mAddr) | 8'h80);
    rd(`USBCR_IDX_ADDR, mAddr, "addr");
    k = $urandom_range(255, 0);
    wr(`USBCR_IDX_FWST, 8'(k));
    rd(`USBCR_IDX_FWST, k, "fwst");
    chk("enum", 32'(enumState), k & 3);
    apb(1'b0, 12'h19b, 8'h00, rdv, erv);
    chk("err", 32'(erv), 1);
    chk("errdata", rdv, 0);
    // Every enable code on endpoint one, each token kind
    for (i = 0; i < 16; i++)
    begin
      mEp[1] = i;
      wr(`USBCR_IDX_EP1, 8'(i) | 8'hf0);
      rd(`USBCR_IDX_EP1, i, "ep");
      for (k = 0; k < 3; k++) tok(1, k, mAddr);
    end
    tok(1, 1, mAddr ^ 1);
    tok(3, 1, mAddr);
    haltClr <= 3'h2;
    @(posedge clk_sys);
    haltClr <= 3'h0;
    @(posedge clk_sys);
    rd(`USBCR_IDX_EP1, 14, "halt");
    // Engine set and clear in one cycle: the set wins
    {haltSet, haltClr} <= 6'h12;
    @(posedge clk_sys);
    {haltSet, haltClr} <= 6'h00;
    @(posedge clk_sys);
    rd(`USBCR_IDX_EP1, 15, "halt");
    wr(`USBCR_IDX_CTRL, 8'h0c);
    pwr(4'hf);
    wr(`USBCR_IDX_CTRL, 8'h08);
    setupHoldReq <= 1'b1;
    @(posedge clk_sys);
    setupHoldReq <= 1'b0;
    @(posedge clk_sys);
    rd(`USBCR_IDX_CTRL, 32'h18, "hold");
    chk("holdpin", 32'(packetHold), 1);
    mOff = 1;
    tok(1, 1, mAddr);
    wr(`USBCR_IDX_CTRL, 8'h1a);
    pwr(4'h8);
    tok(1, 1, mAddr);
    wr(`USBCR_IDX_CTRL, 8'h0a);
    rd(`USBCR_IDX_CTRL, 32'h1a, "hold");
    wr(`USBCR_IDX_CTRL, 8'h18);
    wr(`USBCR_IDX_CTRL, 8'h08);
    rd(`USBCR_IDX_CTRL, 32'h08, "hold");
    mOff = 0;
    // Two bus reset episodes; each must flag once
    for (i = 0; i < 2; i++)
    begin
      mode <= 2'h1;
      repeat (5) @(posedge clk_sys);
      rd(`USBCR_IDX_CTRL, 32'h28, "se0");
      repeat (50) @(posedge clk_sys);
      mode <= 2'h0;
      repeat (4) @(posedge clk_sys);
      chk("brst", pulses, i + 1);
    end
    mAddr = 0;
    rd(`USBCR_IDX_ADDR, 0, "addr");
    for (i = 0; i < 3; i++) rd(12'(`USBCR_IDX_EP0 + i), 0, "ep");
    // Firmware reconfigures after the bus reset and answers at address zero
    wr(`USBCR_IDX_EP0, 8'h06);
    wr(`USBCR_IDX_EP2, 8'h00);
    mEp = '{6, 0, 0};
    tok(0, 2, 0);
    tok(2, 1, 0);
    // Activity restarts the idle timer
    mode <= 2'h2;
    repeat (4) @(posedge clk_sys);
    mode <= 2'h0;
    repeat (IDLE - 5) @(posedge clk_sys);
    #1;
    chk("idle", 32'(busIdleFlag), 0);
    repeat (15) @(posedge clk_sys);
    chk("idle", 32'(busIdleFlag), 1);
    // Suspend on idle, leave it again once activity returns
    wr(`USBCR_IDX_CTRL, 8'h0a);
    pwr(4'h8);
    mode <= 2'h2;
    repeat (4) @(posedge clk_sys);
    wr(`USBCR_IDX_CTRL, 8'h08);
    chk("idle", 32'(busIdleFlag), 0);
    pwr(4'hd);
    final_report();
  end
endmodule // usbcr_ctrl_regs_bench
bind usbcr_ctrl_regs usbcr_ctrl_regs_chk chk_u (.clk_sys, .rst, .psel, .penable, .prdata, .pready, .pslverr,
  .lineDp, .lineDm, .setupHoldReq, .tokValid, .tokAccept, .tokStall, .tokIgnore, .busSupplyEn, .xcvrOutEn,
  .resumeDrive, .usbClkEn, .packetHold, .busResetPulse, .busIdleFlag);
`default_nettype wire
